// ==== logic/quadrature_encoder_line_trigger.sv ====
// Purpose: quadrature decode, line qualification and scan step trigger
// Assumes: phase inputs asynchronous; channel zero signals on clk_sys
// Notes:   divider itself lives outside; only its controls pass through
//
// Decided for this implementation: the placing of the registers and strobed register access.
module quadrature_encoder_line_trigger
  import qenc_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // register port
  input  wire logic [3:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic      [31:0]        rdata,
  // encoder phases
  input  wire logic               phase_a_pin,
  input  wire logic               phase_b_pin,
  // channel zero and divider
  input  wire logic               quad_out_ch0,
  input  wire logic               divider_out_ch0,
  input  wire logic               divider_out_local,
  output logic                    divider_in,
  output logic [2:0]              divider_n_factor,
  output logic [9:0]              divider_m_factor,
  // triggers
  output logic                    quad_out_local,
  output logic                    selected_encoder_signal,
  output logic                    selected_divider_signal,
  output logic                    step_trigger
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // returns {valid, up} for a phase change
  function automatic logic [1:0] decode_step(input logic [1:0] prev,
                                             input logic [1:0] cur,
                                             input logic       four_x);
    logic [1:0] res;
    res = 2'b00;
    unique case ({prev, cur})
      4'b00_10: res = 2'b11;
      4'b10_11: res = 2'b11;
      4'b00_01: res = 2'b10;
      4'b01_11: res = 2'b10;
      4'b11_01: res = four_x ? 2'b11 : 2'b00;
      4'b01_00: res = four_x ? 2'b11 : 2'b00;
      4'b11_10: res = four_x ? 2'b10 : 2'b00;
      4'b10_00: res = four_x ? 2'b10 : 2'b00;
      default:  res = 2'b00;
    endcase
    return res;
  endfunction : decode_step

  function automatic logic in_range(input logic [COUNT_W-1:0] v,
                                    input logic [COUNT_W-1:0] lo,
                                    input logic [COUNT_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range

  // true when a count lies outside the visited span
  function automatic logic outside_span(input logic [COUNT_W-1:0] v,
                                        input logic [COUNT_W-1:0] lo,
                                        input logic [COUNT_W-1:0] hi);
    return (v < lo) || (v > hi);
  endfunction : outside_span

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  select_ctrl_s        sel_q;
  mode_ctrl_s          mode_q;
  limit_ctrl_s         lim_q;
  logic                sys_reset_q;
  logic                revisit_clear_q;
  logic [31:0]         rdata_q;
  mode_ctrl_s          wr_mode;
  limit_ctrl_s         wr_limit;
  logic                wr_mode_hit;
  logic                wr_limit_hit;

  // write-only bits seen through the field layouts
  assign wr_mode      = mode_ctrl_s'(wdata);
  assign wr_limit     = limit_ctrl_s'(wdata);
  assign wr_mode_hit  = wr_en && addr == ADDR_MODE_CTRL;
  assign wr_limit_hit = wr_en && addr == ADDR_LIMIT_CTRL;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q  <= select_ctrl_s'(SELECT_RESET);
      mode_q <= mode_ctrl_s'(MODE_RESET);
      lim_q  <= limit_ctrl_s'(LIMIT_RESET);
    end else if (wr_en) begin
      unique case (addr)
        ADDR_SELECT_CTRL: sel_q <= select_ctrl_s'(wdata);
        ADDR_MODE_CTRL: begin
          mode_q                      <= mode_ctrl_s'(wdata);
          mode_q.encoder_system_reset <= 1'b0;
          mode_q.unused_29            <= 1'b0;
        end
        ADDR_LIMIT_CTRL: begin
          lim_q               <= limit_ctrl_s'(wdata);
          lim_q.revisit_clear <= 1'b0;
          lim_q.unused_31_27  <= 5'h00;
        end
        default: ;
      endcase
    end
  end

  // write-only pulses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_q     <= 1'b0;
      revisit_clear_q <= 1'b0;
    end else begin
      sys_reset_q     <= wr_mode_hit && wr_mode.encoder_system_reset;
      revisit_clear_q <= wr_limit_hit && wr_limit.revisit_clear;
    end
  end

  // ----------------------------------------------------------------
  // phase synchronisers and decode
  // ----------------------------------------------------------------
  logic [1:0]          ab_meta_q;
  logic [1:0]          ab_sync_q;
  logic [1:0]          ab_prev_q;
  logic [1:0]          step_info;
  logic                count_step;
  logic                count_up;
  logic [COUNT_W-1:0]  count_q;
  logic [COUNT_W-1:0]  count_next;
  logic                dir_up_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ab_meta_q <= 2'b00;
      ab_sync_q <= 2'b00;
      ab_prev_q <= 2'b00;
    end else begin
      ab_meta_q <= {phase_a_pin, phase_b_pin};
      ab_sync_q <= ab_meta_q;
      ab_prev_q <= ab_sync_q;
    end
  end

  assign step_info  = decode_step(ab_prev_q, ab_sync_q,
                                  mode_q.edge_resolution_select);
  assign count_step = step_info[1] && !sys_reset_q;
  assign count_up   = step_info[0];
  assign count_next = count_up ? count_q + 24'h000001 : count_q - 24'h000001;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q  <= 24'h000000;
      dir_up_q <= 1'b1;
    end else if (sys_reset_q) begin
      count_q  <= 24'h000000;
      dir_up_q <= 1'b1;
    end else if (count_step) begin
      count_q  <= count_next;
      dir_up_q <= count_up;
    end
  end

  // ----------------------------------------------------------------
  // qualification
  // ----------------------------------------------------------------
  logic                dir_ok;
  logic                interval_ok;
  logic                new_ok;
  logic                line_fire;
  logic                inside_now;
  logic                record_valid_q;
  logic [COUNT_W-1:0]  visit_lo_q;
  logic [COUNT_W-1:0]  visit_hi_q;
  logic                auto_exit;
  logic                record_clear;
  logic                span_restart;

  always_comb begin
    unique case (mode_q.acquire_direction)
      DIR_BOTH: dir_ok = 1'b1;
      DIR_POS:  dir_ok = count_up;
      DIR_NEG:  dir_ok = !count_up;
      default:  dir_ok = 1'b0;
    endcase
  end

  assign inside_now  = in_range(count_q, mode_q.interval_lower_limit,
                                lim_q.interval_upper_limit);
  assign interval_ok = !mode_q.interval_enable ||
                       in_range(count_next, mode_q.interval_lower_limit,
                                lim_q.interval_upper_limit);
  assign new_ok      = !mode_q.no_revisit_enable || span_restart ||
                       outside_span(count_next, visit_lo_q, visit_hi_q);
  assign line_fire   = count_step && dir_ok && interval_ok && new_ok;

  always_comb begin
    unique case (mode_q.acquire_direction)
      DIR_POS: auto_exit = count_q > lim_q.interval_upper_limit;
      DIR_NEG: auto_exit = count_q < mode_q.interval_lower_limit;
      default: auto_exit = !inside_now;
    endcase
  end

  assign record_clear = sys_reset_q || revisit_clear_q ||
                        (lim_q.revisit_clear_mode == CLEAR_AUTO && auto_exit);

  // a clear drops the old span even when a line fires beside it
  assign span_restart = !record_valid_q || record_clear;

  // visited counts form one contiguous span, since the count moves by one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      record_valid_q <= 1'b0;
      visit_lo_q     <= 24'h000000;
      visit_hi_q     <= 24'h000000;
    end else if (line_fire) begin
      record_valid_q <= 1'b1;
      visit_lo_q     <= (span_restart || count_next < visit_lo_q) ? count_next
                                                                  : visit_lo_q;
      visit_hi_q     <= (span_restart || count_next > visit_hi_q) ? count_next
                                                                  : visit_hi_q;
    end else if (record_clear) begin
      record_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // scan step
  // ----------------------------------------------------------------
  logic [15:0]         step_cnt_q;
  logic                step_fire;

  assign step_fire = line_fire && mode_q.step_trigger_enable &&
                     (step_cnt_q + 16'h0001 >= sel_q.scan_step_count);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_q <= 16'h0000;
    end else if (sys_reset_q || !mode_q.step_trigger_enable || step_fire) begin
      step_cnt_q <= 16'h0000;
    end else if (line_fire) begin
      step_cnt_q <= step_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  logic                quad_local_q;
  logic                step_trig_q;
  logic                enc_sel_q;
  logic                div_in_q;
  logic                div_sel_q;
  logic                quad_chosen;

  assign quad_chosen = sel_q.quad_output_source ? quad_out_ch0 : quad_local_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quad_local_q <= 1'b0;
      step_trig_q  <= 1'b0;
      enc_sel_q    <= 1'b0;
      div_in_q     <= 1'b0;
      div_sel_q    <= 1'b0;
    end else begin
      quad_local_q <= line_fire;
      step_trig_q  <= step_fire;
      enc_sel_q    <= mode_q.step_trigger_enable ? step_trig_q : quad_chosen;
      div_in_q     <= sel_q.divider_input_source ? quad_local_q
                                                 : ab_sync_q[1];
      div_sel_q    <= sel_q.divider_output_source ? divider_out_ch0
                                                  : divider_out_local;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  status_s             stat;

  always_comb begin
    stat                 = '0;
    stat.position_count  = count_q;
    stat.phase_a         = ab_sync_q[1];
    stat.phase_b         = ab_sync_q[0];
    stat.direction_up    = dir_up_q;
    stat.inside_interval = inside_now;
    stat.new_lines       = !record_valid_q ||
                           outside_span(count_q, visit_lo_q, visit_hi_q);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr)
        ADDR_SELECT_CTRL: rdata_q <= sel_q;
        ADDR_MODE_CTRL:   rdata_q <= mode_q;
        ADDR_LIMIT_CTRL:  rdata_q <= lim_q;
        ADDR_STATUS:      rdata_q <= stat;
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata                   = rdata_q;
  assign divider_n_factor        = sel_q.divider_n_factor;
  assign divider_m_factor        = sel_q.divider_m_factor;
  assign quad_out_local          = quad_local_q;
  assign selected_encoder_signal = enc_sel_q;
  assign selected_divider_signal = div_sel_q;
  assign divider_in              = div_in_q;
  assign step_trigger            = step_trig_q;

endmodule : quadrature_encoder_line_trigger

// ==== logic/qenc_pkg.sv ====
// Purpose: constants and carriers for the quadrature encoder line trigger
// Assumes: one 20 MHz clock, 32-bit plain register port
// Notes:   register word offsets are byte addresses
//
// How it works
// - quad source bit picks own or channel zero
// - divider input is phase A or quad output
// - divider output source picks own or channel zero
// - divider N factor in bits 5..3
// - divider M factor in bits 15..6
// - scan step count in bits 31..16
// - scan step counts only fully qualified pulses
// - interval lower limit in bits 23..0
// - decode bit selects 2x or 4x edges
// - direction field: both, positive, negative, reserved
// - interval mode gates lines by limits
// - direction setting applies with or without interval mode
// - no-revisit off: every qualified change triggers
// - no-revisit on: one line per count value
// - scan step issues trigger every N lines
// - step enable picks quad or scan output
// - write-only bit 31 resets counter, direction, visit record and step count
// - 24-bit position counter counts up or down
// - interval upper limit in bits 23..0
// - auto mode clears record when count exits
package qenc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SELECT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MODE_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_LIMIT_CTRL  = 4'h8;
  localparam logic [3:0] ADDR_STATUS      = 4'hc;

  localparam int COUNT_W = 24;

  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_POS  = 2'h1;
  localparam logic [1:0] DIR_NEG  = 2'h2;

  localparam logic [1:0] CLEAR_MANUAL = 2'h0;
  localparam logic [1:0] CLEAR_AUTO   = 2'h1;

  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RESET  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] scan_step_count;
    logic [9:0]  divider_m_factor;
    logic [2:0]  divider_n_factor;
    logic        divider_output_source;
    logic        divider_input_source;
    logic        quad_output_source;
  } select_ctrl_s;

  typedef struct packed {
    logic                encoder_system_reset;
    logic                step_trigger_enable;
    logic                unused_29;
    logic                no_revisit_enable;
    logic                interval_enable;
    logic [1:0]          acquire_direction;
    logic                edge_resolution_select;
    logic [COUNT_W-1:0]  interval_lower_limit;
  } mode_ctrl_s;

  typedef struct packed {
    logic [4:0]          unused_31_27;
    logic                revisit_clear;
    logic [1:0]          revisit_clear_mode;
    logic [COUNT_W-1:0]  interval_upper_limit;
  } limit_ctrl_s;

  typedef struct packed {
    logic [2:0]          unused_31_29;
    logic                new_lines;
    logic                inside_interval;
    logic                direction_up;
    logic                phase_b;
    logic                phase_a;
    logic [COUNT_W-1:0]  position_count;
  } status_s;

endpackage : qenc_pkg

// ==== sim/quad_encoder_model.sv ====
// Purpose: behavioural quadrature encoder on a moving stage
// Assumes: one phase step per request, caller spaces the requests
// Notes:   phases start at 00 and are always driven
module quad_encoder_model (
  // clock and step request
  input  wire logic clk_sys,
  input  wire logic step,
  input  wire logic up,
  // encoder phases
  output logic      phase_a_pin,
  output logic      phase_b_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos_q = 2'h0;
  // --------------------------------
  // gray walk 00,10,11,01 going up
  // --------------------------------
  always @(posedge clk_sys) begin
    if (step) pos_q <= up ? pos_q + 2'h1 : pos_q - 2'h1;
  end
  assign phase_a_pin = pos_q[0] ^ pos_q[1];
  assign phase_b_pin = pos_q[1];
endmodule : quad_encoder_model

// ==== sim/quadrature_encoder_line_trigger_checker.sv ====
// Purpose: port assertions for the encoder line trigger
// Assumes: shadow copies of select and mode follow the writes
// Notes:   bound below
module quadrature_encoder_line_trigger_checker
  import qenc_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // register port
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  // divider and triggers
  input wire logic        quad_out_ch0,
  input wire logic        divider_out_ch0,
  input wire logic        divider_out_local,
  input wire logic        divider_in,
  input wire logic [2:0]  divider_n_factor,
  input wire logic [9:0]  divider_m_factor,
  input wire logic        quad_out_local,
  input wire logic        selected_encoder_signal,
  input wire logic        selected_divider_signal,
  input wire logic        step_trigger
);
  logic [31:0] sel_q;
  logic [31:0] mode_q;
  logic        enc_src;
  logic        div_src;
  logic        div_fb;
  // --------------------------------
  // register shadows
  // --------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) sel_q <= SELECT_RESET;
    else if (wr_en && addr == ADDR_SELECT_CTRL) sel_q <= wdata;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) mode_q <= MODE_RESET;
    else if (wr_en && addr == ADDR_MODE_CTRL) mode_q <= wdata;
  end
  assign enc_src = mode_q[30] ? step_trigger : (sel_q[0] ? quad_out_ch0 : quad_out_local);
  assign div_src = sel_q[2] ? divider_out_ch0 : divider_out_local;
  assign div_fb  = sel_q[1];
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence sel_read;
    rd_en && addr == ADDR_SELECT_CTRL;
  endsequence
  sequence line_pulse;
    quad_out_local;
  endsequence
  rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside its slot");
  rd_sel_a: assert property (sel_read |=> rdata == $past(sel_q))
    else $error("select readback wrong");
  div_n_a: assert property (divider_n_factor == sel_q[5:3])
    else $error("n factor wrong");
  div_m_a: assert property (divider_m_factor == sel_q[15:6])
    else $error("m factor wrong");
  enc_sel_a: assert property (
    $past(rst_n) |-> selected_encoder_signal == $past(enc_src))
    else $error("encoder select wrong");
  div_sel_a: assert property ($past(rst_n) |-> selected_divider_signal == $past(div_src))
    else $error("divider select wrong");
  div_in_a: assert property (
    $past(rst_n) && $past(div_fb) |-> divider_in == $past(quad_out_local))
    else $error("divider feed wrong");
  line_once_a: assert property (line_pulse |=> !quad_out_local)
    else $error("line pulse too long");
  step_qual_a: assert property (step_trigger |-> line_pulse)
    else $error("step without line");
endmodule : quadrature_encoder_line_trigger_checker

bind quadrature_encoder_line_trigger quadrature_encoder_line_trigger_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .quad_out_ch0(quad_out_ch0),
  .divider_out_ch0(divider_out_ch0), .divider_out_local(divider_out_local),
  .divider_in(divider_in), .divider_n_factor(divider_n_factor),
  .divider_m_factor(divider_m_factor), .quad_out_local(quad_out_local),
  .selected_encoder_signal(selected_encoder_signal),
  .selected_divider_signal(selected_divider_signal), .step_trigger(step_trigger));

// ==== sim/quadrature_encoder_line_trigger_tb.sv ====
// Purpose: self-checking bench for the encoder line trigger
// Assumes: each row's setup writes end with a system reset write
// Notes:   phase states held 6 clocks
module quadrature_encoder_line_trigger_tb
  import qenc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [31:0] sel, mode, lim;
    int          up, dn, up2, lines, trig;
    logic [23:0] cnt;
  } row_s;
  row_s rows [10] = '{
    '{32'h0, 32'h0000_0000, 32'h0, 8, 4, 0, 6, 0, 24'h000002},
    '{32'h0, 32'h0100_0000, 32'h0, 6, 2, 0, 8, 0, 24'h000004},
    '{32'h0, 32'h0300_0000, 32'h0, 5, 3, 2, 7, 0, 24'h000004},
    '{32'h0, 32'h0500_0000, 32'h0, 2, 6, 0, 6, 0, 24'hfffffc},
    '{32'h0, 32'h0700_0000, 32'h0, 4, 0, 0, 0, 0, 24'h000004},
    '{32'h0, 32'h0b00_0002, 32'h4, 6, 6, 0, 3, 0, 24'h000000},
    '{32'h0, 32'h1100_0000, 32'h0, 4, 3, 4, 5, 0, 24'h000005},
    '{32'h0, 32'h1100_0000, 32'h0400_0000, 3, 2, 3, 6, 0, 24'h000004},
    '{32'h0003_0000, 32'h4100_0000, 32'h0, 7, 0, 0, 7, 2, 24'h000007},
    '{32'h0, 32'h1b00_0002, 32'h0100_0004, 6, 6, 6, 6, 0, 24'h000006}};
  logic [3:0]  ra [4] = '{4'h0, 4'h4, 4'h8, 4'h2};
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        quad_out_ch0 = 1'b0;
  logic        divider_out_ch0 = 1'b0;
  logic        divider_out_local = 1'b0;
  logic        step = 1'b0;
  logic        up = 1'b0;
  logic [31:0] rdata, v;
  logic        phase_a_pin, phase_b_pin, divider_in, quad_out_local, step_trigger;
  logic        selected_encoder_signal, selected_divider_signal;
  logic [2:0]  divider_n_factor;
  logic [9:0]  divider_m_factor;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          lines, trigs;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (rst_n) divider_out_local <= ~divider_out_local;
  always @(negedge clk_sys) begin
    lines += (quad_out_local === 1'b1);
    trigs += (step_trigger === 1'b1);
  end
  quad_encoder_model u_enc (.clk_sys(clk_sys), .step(step), .up(up),
    .phase_a_pin(phase_a_pin), .phase_b_pin(phase_b_pin));
  quadrature_encoder_line_trigger u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .phase_a_pin(phase_a_pin), .phase_b_pin(phase_b_pin), .quad_out_ch0(quad_out_ch0),
    .divider_out_ch0(divider_out_ch0), .divider_out_local(divider_out_local),
    .divider_in(divider_in), .divider_n_factor(divider_n_factor),
    .divider_m_factor(divider_m_factor), .quad_out_local(quad_out_local),
    .selected_encoder_signal(selected_encoder_signal),
    .selected_divider_signal(selected_divider_signal), .step_trigger(step_trigger));
  // --------------------------------
  // helpers
  // --------------------------------
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task rd(input logic [3:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
    @(posedge clk_sys);
  endtask : rd
  task move(input int n, input logic dir);
    repeat (n) begin
      step <= 1'b1;
      up <= dir;
      @(posedge clk_sys);
      step <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
  endtask : move
  task tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // --------------------------------
  // sequence
  // --------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      wr(ADDR_SELECT_CTRL, rows[i].sel);
      wr(ADDR_LIMIT_CTRL, rows[i].lim);
      wr(ADDR_MODE_CTRL, rows[i].mode | 32'h8000_0000);
      lines = 0;
      trigs = 0;
      move(rows[i].up, 1'b1);
      move(rows[i].dn, 1'b0);
      if (rows[i].lim[26]) wr(ADDR_LIMIT_CTRL, rows[i].lim);
      move(rows[i].up2, 1'b1);
      repeat (3) @(posedge clk_sys);
      chk(divider_in === phase_a_pin, "divider feed");
      rd(ADDR_STATUS);
      chk(v[23:0] === rows[i].cnt, "position count");
      chk(lines == rows[i].lines, "line count");
      chk(trigs == rows[i].trig, "step triggers");
      rd(ADDR_MODE_CTRL);
      chk(v === rows[i].mode, "mode readback");
    end
    wr(ADDR_MODE_CTRL, 32'h0100_0000);
    wr(ADDR_SELECT_CTRL, 32'h0003_abff);
    chk(divider_n_factor === 3'h7 && divider_m_factor === 10'h2af, "n m fields");
    quad_out_ch0 <= 1'b1;
    divider_out_ch0 <= 1'b1;
    @(posedge clk_sys);
    quad_out_ch0 <= 1'b0;
    divider_out_ch0 <= 1'b0;
    @(negedge clk_sys);
    chk(selected_encoder_signal === 1'b1, "channel zero quad");
    chk(selected_divider_signal === 1'b1, "channel zero divider");
    @(posedge clk_sys);
    move(2, 1'b1);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(v === 32'h0, "reset value");
    end
    rd(ADDR_STATUS);
    chk(v[23:0] === 24'h0, "count after reset");
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end
endmodule : quadrature_encoder_line_trigger_tb
